// [design/pdm_audio_defs.vh]
/*
 * timing, widths and window constants for the microphone capture and audio output path.
 * assumes a 100 MHz system clock.
 */
`ifndef PDM_AUDIO_DEFS_VH
`define PDM_AUDIO_DEFS_VH

`define CLK_FREQ_HZ        100000000
`define MIC_CLK_MIN_HZ     1000000
`define MIC_CLK_MAX_HZ     3300000
`define MIC_CLK_TYP_HZ     2400000
`define MIC_HALF_DIV       ((`CLK_FREQ_HZ + 2 * `MIC_CLK_TYP_HZ - 1) / (2 * `MIC_CLK_TYP_HZ))
`define MIC_HALF_W         5
`define WIN_LEN            128
`define WIN_HALF           64
`define WIN_CNT_W          7
`define SAMPLE_W           8
`define PWM_FREQ_HZ        390625
`define PWM_PERIOD         (`CLK_FREQ_HZ / `PWM_FREQ_HZ)
`define PWM_CNT_W          8
`define FIFO_DEPTH         16
`define FIFO_AW            4

`endif

// [design/sample_fifo.v]
/*
 * synchronous fifo with valid/ready on both sides.
 * assumes one clock, active low asynchronous reset, clock enable.
 */
`timescale 1ns/100ps
module sample_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clock,
    input  wire             resetn,
    input  wire             clk_en,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wr_ptr_ff;
    reg [AW:0]      rd_ptr_ff;
    wire            full;
    wire            empty;
    wire            push;
    wire            pop;

    assign full      = (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]) && (wr_ptr_ff[AW] != rd_ptr_ff[AW]);
    assign empty     = (wr_ptr_ff == rd_ptr_ff);
    assign in_ready  = ~full;
    assign out_valid = ~empty;
    assign out_data  = mem[rd_ptr_ff[AW-1:0]];
    assign push      = clk_en & in_valid & ~full;
    assign pop       = clk_en & out_ready & ~empty;

    always @(posedge clock)
    begin
        if (push)
            mem[wr_ptr_ff[AW-1:0]] <= in_data;
    end

    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            wr_ptr_ff <= {(AW+1){1'b0}};
            rd_ptr_ff <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            if (pop)
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
        end
    end
endmodule

// [design/ones_counter.v]
/*
 * one decimation ones-counter: counts ones over a window, latches and clears.
 * assumes bit_en pulses once per captured microphone bit.
 */
`timescale 1ns/100ps
`include "pdm_audio_defs.vh"
module ones_counter (
    input  wire                 clock,
    input  wire                 resetn,
    input  wire                 clk_en,
    input  wire                 bit_en,
    input  wire                 bit_val,
    input  wire                 win_end,
    output reg  [`SAMPLE_W-1:0] sample_ff,
    output reg                  done_ff
);
    reg [`SAMPLE_W-1:0] count_ff;
    wire [`SAMPLE_W-1:0] nxt_count;

    assign nxt_count = count_ff + {{(`SAMPLE_W-1){1'b0}}, bit_val};

    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            count_ff  <= 8'h00;
            sample_ff <= 8'h00;
            done_ff   <= 1'b0;
        end
        else if (clk_en)
        begin
            done_ff <= 1'b0;
            if (bit_en)
            begin
                if (win_end)
                begin
                    // latch and clear at window end
                    sample_ff <= nxt_count;
                    count_ff  <= 8'h00;
                    done_ff   <= 1'b1;
                end
                else
                    count_ff <= nxt_count;
            end
        end
    end
endmodule

// [design/pdm_mic_audio_ctrl.v]
/*
 * user-side controller for a pdm microphone and an open-drain audio output.
 * assumes mic data arrives asynchronously; the microphone itself 
 * so each pdm one is taken as full scale positive. the audio pin has an external pull-up.
 */
// Operation
// - mic clock kept between 1 and 3.3 MHz
// - edge select held at valid level
// - low: rising edge capture; high: falling
// - mic clock runs at typical 2.4 MHz
// - count ones over fixed window
// - two 128-sample ones-counters
// - audio out is one-bit pwm
// - drive low for zero, release for one
// - pwm pulses at fixed period
// - pwm frequency well above audio band
// - duty cycle equals sample fraction
`timescale 1ns/100ps
`include "pdm_audio_defs.vh"
module pdm_mic_audio_ctrl (
    input  wire                 clock,
    input  wire                 resetn,
    input  wire                 clk_en,
    input  wire                 edge_sel,
    input  wire                 mic_enable,
    output reg                  mic_clk_ff,
    input  wire                 mic_data,
    output reg                  channel_edge_select,
    output wire                 audio_out_pin_o,
    output wire                 audio_out_pin_oe,
    input  wire                 audio_out_pin_i,
    output reg  [`SAMPLE_W-1:0] mic_sample_ff,
    output reg                  mic_sample_valid_ff,
    input  wire                 play_enable,
    output wire                 sample_ready,
    output wire                 fifo_level_ok
);
    localparam ST_IDLE = 3'b001;
    localparam ST_RUN  = 3'b010;
    localparam ST_STOP = 3'b100;

    localparam integer           HALF_LAST_I = `MIC_HALF_DIV - 1;
    localparam integer           WIN_LAST_I  = `WIN_LEN - 1;
    localparam integer           WIN_MID_I   = `WIN_HALF - 1;
    localparam integer           PWM_LAST_I  = `PWM_PERIOD - 1;
    localparam [`MIC_HALF_W-1:0] HALF_LAST   = HALF_LAST_I[`MIC_HALF_W-1:0];
    localparam [`WIN_CNT_W-1:0]  WIN_LAST    = WIN_LAST_I[`WIN_CNT_W-1:0];
    localparam [`WIN_CNT_W-1:0]  WIN_MID     = WIN_MID_I[`WIN_CNT_W-1:0];
    localparam [`PWM_CNT_W-1:0]  PWM_LAST    = PWM_LAST_I[`PWM_CNT_W-1:0];

    reg [2:0]             state_ff;
    reg [2:0]             nxt_state;
    reg [`MIC_HALF_W-1:0] div_ff;
    reg                   data_s1_ff;
    reg                   data_s2_ff;
    reg                   data_bit_ff;
    reg                   bit_en_ff;
    reg [`WIN_CNT_W-1:0]  win_ff;
    reg                   edge_lat_ff;
    reg [`PWM_CNT_W-1:0]  pwm_cnt_ff;
    reg [`SAMPLE_W-1:0]   duty_ff;
    reg                   pwm_high_ff;
    reg [`MIC_HALF_W-1:0] nxt_div;
    reg                   nxt_mic_clk;
    reg                   nxt_edge;
    reg [`WIN_CNT_W-1:0]  nxt_win;
    reg [`PWM_CNT_W-1:0]  nxt_pwm_cnt;
    reg [`SAMPLE_W-1:0]   nxt_duty;
    reg                   nxt_pwm_high;
    reg [`SAMPLE_W-1:0]   nxt_sample;
    reg                   nxt_sample_valid;
    wire                  half_tick;
    wire                  rise_now;
    wire                  fall_now;
    wire                  cap_edge;
    wire                  win_end_a;
    wire                  win_end_b;
    wire [`SAMPLE_W-1:0]  sample_a;
    wire [`SAMPLE_W-1:0]  sample_b;
    wire                  done_a;
    wire                  done_b;
    wire                  fifo_in_ready;
    wire [`SAMPLE_W-1:0]  fifo_out_data;
    wire                  fifo_out_valid;
    wire                  pwm_period_end;
    wire                  running;

    assign running   = (state_ff == ST_RUN);
    assign half_tick = (div_ff == HALF_LAST);
    assign rise_now  = running & half_tick & ~mic_clk_ff;
    assign fall_now  = running & half_tick & mic_clk_ff;

    assign cap_edge  = edge_lat_ff ? fall_now : rise_now;

    always @*
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:
                if (mic_enable)
                    nxt_state = ST_RUN;
            ST_RUN:
                if (!mic_enable)
                    nxt_state = ST_STOP;
            ST_STOP:
                if (!mic_clk_ff)
                    nxt_state = ST_IDLE;
                else if (half_tick)
                    nxt_state = ST_IDLE;
            default:
                nxt_state = ST_IDLE;
        endcase
    end

    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            state_ff            <= ST_IDLE;
            div_ff              <= 5'h00;
            mic_clk_ff          <= 1'b0;
            channel_edge_select <= 1'b0;
            edge_lat_ff         <= 1'b0;
        end
        else if (clk_en)
        begin
            state_ff            <= nxt_state;
            div_ff              <= nxt_div;
            mic_clk_ff          <= nxt_mic_clk;
            channel_edge_select <= nxt_edge;
            edge_lat_ff         <= nxt_edge;
        end
    end

    // divider sets 2.4 MHz mic clock
    always @*
    begin
        nxt_div     = div_ff + 5'h01;
        nxt_mic_clk = mic_clk_ff;
        if ((state_ff == ST_IDLE) | half_tick)
            nxt_div = 5'h00;
        if ((running | (state_ff == ST_STOP)) & half_tick)
            nxt_mic_clk = ~mic_clk_ff;
    end

    // edge select latched while idle, held during use
    always @*
    begin
        nxt_edge = edge_lat_ff;
        if (state_ff == ST_IDLE)
            nxt_edge = edge_sel;
    end

    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            data_s1_ff  <= 1'b0;
            data_s2_ff  <= 1'b0;
            data_bit_ff <= 1'b0;
            bit_en_ff   <= 1'b0;
            win_ff      <= 7'h00;
        end
        else if (clk_en)
        begin
            data_s1_ff <= mic_data;
            data_s2_ff <= data_s1_ff;
            bit_en_ff  <= cap_edge;
            if (cap_edge)
                data_bit_ff <= data_s2_ff;
            win_ff <= nxt_win;
        end
    end

    always @*
    begin
        nxt_win = win_ff;
        if (state_ff == ST_IDLE)
            nxt_win = 7'h00;
        else if (bit_en_ff)
            nxt_win = win_ff + 7'h01;
    end

    // counters end half a window apart
    assign win_end_a = (win_ff == WIN_LAST);
    assign win_end_b = (win_ff == WIN_MID);

    ones_counter u_count_a (
        .clock     (clock),
        .resetn    (resetn),
        .clk_en    (clk_en),
        .bit_en    (bit_en_ff),
        .bit_val   (data_bit_ff),
        .win_end   (win_end_a),
        .sample_ff (sample_a),
        .done_ff   (done_a)
    );

    ones_counter u_count_b (
        .clock     (clock),
        .resetn    (resetn),
        .clk_en    (clk_en),
        .bit_en    (bit_en_ff),
        .bit_val   (data_bit_ff),
        .win_end   (win_end_b),
        .sample_ff (sample_b),
        .done_ff   (done_b)
    );

    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            mic_sample_ff       <= 8'h00;
            mic_sample_valid_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            mic_sample_valid_ff <= nxt_sample_valid;
            mic_sample_ff       <= nxt_sample;
        end
    end

    // latest finished counter becomes the output sample
    always @*
    begin
        nxt_sample       = mic_sample_ff;
        nxt_sample_valid = done_a | done_b;
        if (done_a)
            nxt_sample = sample_a;
        else if (done_b)
            nxt_sample = sample_b;
    end

    assign sample_ready  = fifo_in_ready;
    assign fifo_level_ok = fifo_out_valid;

    sample_fifo #(
        .WIDTH (`SAMPLE_W),
        .DEPTH (`FIFO_DEPTH),
        .AW    (`FIFO_AW)
    ) u_fifo (
        .clock     (clock),
        .resetn    (resetn),
        .clk_en    (clk_en),
        .in_data   (mic_sample_ff),
        .in_valid  (mic_sample_valid_ff),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out_data),
        .out_valid (fifo_out_valid),
        .out_ready (play_enable & pwm_period_end)
    );

    assign pwm_period_end = (pwm_cnt_ff == PWM_LAST);

    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            pwm_cnt_ff  <= 8'h00;
            duty_ff     <= 8'h00;
            pwm_high_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            pwm_cnt_ff  <= nxt_pwm_cnt;
            duty_ff     <= nxt_duty;
            pwm_high_ff <= nxt_pwm_high;
        end
    end

    always @*
    begin
        nxt_pwm_cnt  = pwm_cnt_ff + 8'h01;
        nxt_duty     = duty_ff;
        nxt_pwm_high = play_enable & ({1'b0, pwm_cnt_ff[`PWM_CNT_W-1:1]} < duty_ff);
        if (pwm_period_end)
        begin
            nxt_pwm_cnt = 8'h00;
            if (play_enable & fifo_out_valid)
                nxt_duty = fifo_out_data;
            else if (!play_enable)
                nxt_duty = 8'h00;
        end
    end

    // open drain: drive low, release high
    assign audio_out_pin_o  = 1'b0;
    assign audio_out_pin_oe = ~pwm_high_ff;
endmodule

// [bench/mic_audio_sva.sv]
/* port assertions for the microphone and audio output controller.
   assumes clk_en held high and an external pull-up on the audio pin. */
`timescale 1ns/100ps
`include "pdm_audio_defs.vh"
module mic_audio_sva (
    input wire                 clock,
    input wire                 resetn,
    input wire                 mic_clk_ff,
    input wire                 channel_edge_select,
    input wire                 audio_out_pin_o,
    input wire                 audio_out_pin_oe,
    input wire [`SAMPLE_W-1:0] mic_sample_ff,
    input wire                 mic_sample_valid_ff
);
    logic [15:0] half_ff, gap_ff, pwm_ff;
    logic        prev_ff, oe_prev_ff, seen_ff, fseen_ff;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            {half_ff, gap_ff, pwm_ff} <= '0;
            {prev_ff, seen_ff, fseen_ff} <= '0;
            oe_prev_ff <= 1'b1;
        end
        else
        begin
            prev_ff <= mic_clk_ff;
            oe_prev_ff <= audio_out_pin_oe;
            half_ff <= (mic_clk_ff != prev_ff) ? 16'h0000 : half_ff + 16'(half_ff != 16'hFFFF);
            gap_ff <= mic_sample_valid_ff ? 16'h0000 : gap_ff + 16'(gap_ff != 16'hFFFF);
            pwm_ff <= (oe_prev_ff && !audio_out_pin_oe) ? 16'h0000 : pwm_ff + 16'h0001;
            seen_ff <= seen_ff | mic_sample_valid_ff;
            fseen_ff <= fseen_ff | (oe_prev_ff && !audio_out_pin_oe);
        end
    end
    sequence pulse_end;
        mic_sample_valid_ff ##1 !mic_sample_valid_ff;
    endsequence
    pin_never_high_a: assert property (audio_out_pin_o == 1'b0)
        else $error("audio pin driven high");
    clk_high_time_a: assert property ($fell(mic_clk_ff) |-> half_ff == 16'h0014)
        else $error("mic clock high time wrong");
    clk_low_time_a: assert property ($rose(mic_clk_ff) |-> half_ff >= 16'h0014)
        else $error("mic clock low time short");
    select_held_a: assert property (mic_clk_ff |-> $stable(channel_edge_select))
        else $error("edge select moved while running");
    valid_pulse_a: assert property (mic_sample_valid_ff |-> pulse_end)
        else $error("sample valid longer than a cycle");
    sample_range_a: assert property (mic_sample_valid_ff |-> mic_sample_ff <= 8'h80)
        else $error("sample above window size");
    sample_hold_a: assert property (!mic_sample_valid_ff |-> $stable(mic_sample_ff))
        else $error("sample changed without valid");
    valid_spacing_a: assert property (mic_sample_valid_ff && seen_ff |-> gap_ff >= 16'h0A7F)
        else $error("samples closer than half a window");
    pwm_period_a: assert property ($fell(audio_out_pin_oe) && fseen_ff |-> pwm_ff[7:0] == 8'hFF)
        else $error("pwm period not fixed");
endmodule
bind pdm_mic_audio_ctrl mic_audio_sva u_mic_audio_sva (.clock, .resetn, .mic_clk_ff, .channel_edge_select,
    .audio_out_pin_o, .audio_out_pin_oe, .mic_sample_ff, .mic_sample_valid_ff);

// [bench/pdm_mic_model.sv]
/* pdm microphone model: delta-sigma stream of a set density out of 128.
   assumes the clock idles low outside use. */
`timescale 1ns/100ps
module pdm_mic_model (
    input  wire       mic_clk,
    input  wire       select,
    input  wire [7:0] level,
    output logic      data
);
    int   acc = 0;
    logic bit_ff = 1'b0;
    initial data = 1'b0;
    task automatic step();
        acc = acc + level;
        bit_ff = (acc >= 128);
        if (bit_ff)
            acc = acc - 128;
    endtask
    always @(posedge mic_clk or negedge mic_clk)
    begin
        if (mic_clk == select)
        begin
            step();
            data <= bit_ff;
        end
        else
            data <= #40 ~bit_ff;
    end
endmodule

// [bench/pdm_mic_capture_pwm_audio_out_bench.sv]
/* bench for the microphone capture and audio output controller.
   assumes the microphone model and a 100 MHz clock. */
`timescale 1ns/100ps
`include "pdm_audio_defs.vh"
module pdm_mic_capture_pwm_audio_out_bench;
    logic                 clock, resetn, clk_en, edge_sel, mic_enable, play_enable;
    logic [7:0]           level;
    wire                  mic_clk_ff, mic_data, channel_edge_select, pin_o, pin_oe, sample_ready;
    wire                  fifo_level_ok, valid;
    wire [`SAMPLE_W-1:0]  sample;
    wire                  pin_level = pin_oe ? pin_o : 1'b1;
    int                   err_total = 0, samples_checked = 0, run = 0, hits = 0, longest = 0, n;
    // rows: select, density, expected sample
    logic [7:0]           rows [4][3] = '{'{8'h00, 8'h80, 8'h80}, '{8'h01, 8'h33, 8'h33},
                                          '{8'h01, 8'h00, 8'h00}, '{8'h00, 8'h40, 8'h40}};
    pdm_mic_audio_ctrl u_pdm_mic_audio_ctrl (.clock(clock), .resetn(resetn), .clk_en(clk_en),
        .edge_sel(edge_sel), .mic_enable(mic_enable), .mic_clk_ff(mic_clk_ff), .mic_data(mic_data),
        .channel_edge_select(channel_edge_select), .audio_out_pin_o(pin_o), .audio_out_pin_oe(pin_oe),
        .audio_out_pin_i(pin_level), .mic_sample_ff(sample), .mic_sample_valid_ff(valid),
        .play_enable(play_enable), .sample_ready(sample_ready), .fifo_level_ok(fifo_level_ok));
    pdm_mic_model u_pdm_mic_model (.mic_clk(mic_clk_ff), .select(channel_edge_select), .level(level),
        .data(mic_data));
    task automatic check(input [7:0] got, input [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic wait_valid();
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end while (valid !== 1'b1 && n < 4000);
        if (n >= 4000)
        begin
            check(8'h00, 8'h01, "sample timeout");
            test_done();
        end
    endtask
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock)
    begin
        if (play_enable)
        begin
            if (pin_level)
                run++;
            else
            begin
                hits += (run == 102);
                longest = (run > longest) ? run : longest;
                run = 0;
            end
        end
    end
    initial
    begin
        {resetn, edge_sel, mic_enable, play_enable} = 4'h0;
        clk_en = 1'b1;
        level = 8'h00;
        repeat (6) @(posedge clock);
        resetn <= 1'b1;
        foreach (rows[i])
        begin
            @(posedge clock);
            edge_sel <= rows[i][0][0];
            level <= rows[i][1];
            repeat (2) @(posedge clock);
            mic_enable <= 1'b1;
            repeat (3) wait_valid();
            repeat (2)
            begin
                wait_valid();
                check(sample, rows[i][2], "sample");
            end
            check(channel_edge_select, rows[i][0], "edge select");
            mic_enable <= 1'b0;
            repeat (60) @(posedge clock);
            check(mic_clk_ff, 8'h00, "clock idle");
            $display("row %0d done", i);
        end
        check(pin_level, 8'h00, "pin idle low");
        check(sample_ready, 8'h00, "fifo full");
        play_enable <= 1'b1;
        n = 0;
        while (fifo_level_ok !== 1'b0 && n < 5000)
        begin
            @(posedge clock);
            n++;
        end
        if (n >= 5000)
            check(8'h00, 8'h01, "drain timeout");
        repeat (600) @(posedge clock);
        check(fifo_level_ok, 8'h00, "fifo drained");
        check(8'(hits > 0), 8'h01, "duty 51 run");
        // three full-scale samples in a row release the pin for three whole periods
        check(8'(longest >= 768), 8'h01, "full scale run");
        $display("playback done");
        mic_enable <= 1'b1;
        wait_valid();
        resetn <= 1'b0;
        #1;
        check({mic_clk_ff, channel_edge_select, pin_oe, valid}, 8'h02, "reset outputs");
        check(sample, 8'h00, "reset sample");
        repeat (6) @(posedge clock);
        resetn <= 1'b1;
        repeat (2) @(posedge clock);
        check({mic_clk_ff, valid}, 8'h00, "after release");
        wait_valid();
        check(channel_edge_select, 8'h00, "select after release");
        $display("reset done");
        test_done();
    end
endmodule
